/* File: hdl/ssu_pkg.sv */
// ==========================================================================
// Shared constants of the synchronous serial unit
`default_nettype none
package ssu_pkg;

  // ========================================================================
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL   = 8'h00; // Mode and frame format
  localparam logic [7:0] OFF_BAUD   = 8'h04; // Baud reload value
  localparam logic [7:0] OFF_TXDATA = 8'h08; // Transmit buffer, write
  localparam logic [7:0] OFF_RXDATA = 8'h0C; // Receive buffer, read
  localparam logic [7:0] OFF_STATUS = 8'h10; // Flags and sticky errors

  // ========================================================================
  // Control field positions
  localparam int CTRL_EN     = 0;  // Port enable
  localparam int CTRL_MASTER = 1;  // 1 = master role
  localparam int CTRL_LSB    = 2;  // 1 = LSB first
  localparam int CTRL_CPOL   = 3;  // Idle level of the shift clock
  localparam int CTRL_CPHA   = 4;  // 1 = sample on trailing edge
  localparam int CTRL_HALF   = 5;  // 1 = half duplex
  localparam int CTRL_TXDIR  = 6;  // Half duplex: 1 = transmit
  localparam int CTRL_WID_LO = 8;  // Bits per word minus one, 3 bits
  localparam int CTRL_W      = 11; // Control register width
  localparam logic [10:0] CTRL_RST = 11'h700; // Eight bits, all else off

  // ========================================================================
  // Status field positions
  localparam int ST_TXE  = 0; // Transmit buffer empty
  localparam int ST_RXF  = 1; // Receive buffer full
  localparam int ST_BUSY = 2; // Word in flight
  localparam int ST_ERR  = 3; // Errors: receive, phase, baud, transmit
  localparam int ERR_RE  = 0; // Receive overrun
  localparam int ERR_PE  = 1; // Phase error
  localparam int ERR_BE  = 2; // Baud rate error
  localparam int ERR_TE  = 3; // Transmit underrun
  localparam logic [15:0] BAUD_RST = 16'h0000; // Fastest rate at reset

  // ========================================================================
  // Shift engine states
  typedef enum logic {SSU_IDLE, SSU_RUN} ssu_state_e;

endpackage
`default_nettype wire

/* File: hdl/ssu_core_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Links the control logic to the baud divider and the shifter
interface ssu_core_if;
  logic [15:0] reload;    // Divider reload value
  logic        run;       // Divider running
  logic        tick;      // Half bit period elapsed
  logic        load;      // Load shift register
  logic [7:0]  load_data; // Word to load
  logic        sample;    // Capture the input bit
  logic        in_bit;    // Input bit
  logic        shift;     // Advance the output bit
  logic        lsb_first; // Shift order
  logic [3:0]  nbits;     // Bits per word, 2..8
  logic        out_bit;   // Current output bit
  logic [7:0]  rx_word;   // Right aligned received word

  modport baud (input reload, run, output tick);
  modport shifter (input load, load_data, sample, in_bit, shift, lsb_first, nbits,
                   output out_bit, rx_word);
  modport ctl (output reload, run, load, load_data, sample, in_bit, shift,
               lsb_first, nbits, input tick, out_bit, rx_word);
endinterface
`default_nettype wire

/* File: hdl/ssu_baud.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// 16-bit reload divider, one tick every reload+1 cycles
module ssu_baud (
  // Clock and reset
  input wire logic   clk_i,
  input wire logic   rst_i,
  // Control side
  ssu_core_if.baud   cif
);
  logic [15:0] cnt; // Down counter

  // Reloads while stopped so the first half period is full length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
    end else if (!cif.run || cnt == 16'h0000) begin
      cnt <= cif.reload;
    end else begin
      cnt <= cnt - 16'h0001;
    end
  end

  assign cif.tick = cif.run && cnt == 16'h0000;
endmodule // ssu_baud
`default_nettype wire

/* File: hdl/ssu_shift.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Transmit and receive shift registers
module ssu_shift (
  // Clock and reset
  input wire logic   clk_i,
  input wire logic   rst_i,
  // Control side
  ssu_core_if.shifter cif
);
  logic [7:0] tx_sh; // Outgoing bits
  logic [7:0] rx_sh; // Incoming bits
  logic [2:0] top;   // Index of the top bit of a word

  assign top = 3'(cif.nbits - 4'h1);

  // Transmit shifter, direction chosen per word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh <= 8'h00;
    end else if (cif.load) begin
      tx_sh <= cif.load_data;
    end else if (cif.shift) begin
      tx_sh <= cif.lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
    end
  end

  // Receive shifter; bits enter at the end that keeps alignment simple
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh <= 8'h00;
    end else if (cif.sample) begin
      rx_sh <= cif.lsb_first ? {cif.in_bit, rx_sh[7:1]} : {rx_sh[6:0], cif.in_bit};
    end
  end

  // Output bit and right aligned word of the configured length
  assign cif.out_bit = cif.lsb_first ? tx_sh[0] : tx_sh[top];
  assign cif.rx_word = cif.lsb_first ? (rx_sh >> (4'h8 - cif.nbits))
                                     : (rx_sh & (8'hFF >> (4'h8 - cif.nbits)));
endmodule // ssu_shift
`default_nettype wire

/* File: hdl/ssu_top.sv */
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module ssu_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial clock pin
  input  wire logic        sclk_i,
  output logic             master_shift_clock_out_o,
  output logic             sclk_oe_o,
  // Master out, slave in pin
  input  wire logic        master_out_slave_in_pin_i,
  output logic             master_out_slave_in_pin_o,
  output logic             master_out_slave_in_pin_oe_o,
  // Master in, slave out pin
  input  wire logic        master_in_slave_out_pin_i,
  output logic             master_in_slave_out_pin_o,
  output logic             master_in_slave_out_pin_oe_o,
  // Service requests; tx and rx are one-cycle pulses, err is high the cycle after each cycle that an error is raised
  output logic             tx_empty_req_o,
  output logic             rx_full_req_o,
  output logic             err_req_o
);

  // ========================================================================
  // Registers and state
  logic [10:0]          ctrl;      // Mode and frame format
  logic [15:0]          baud_rl;   // Baud reload value
  logic [7:0]           tx_buf;    // Transmit holding buffer
  logic                 tx_full;   // Holding buffer occupied
  logic [7:0]           rx_buf;    // Receive holding buffer
  logic                 rx_full;   // Receive buffer unread
  logic [3:0]           err;       // Sticky error flags
  ssu_pkg::ssu_state_e  state;     // Engine state
  logic [3:0]           h;         // Clock edge index in a word
  logic                 loaded;    // Shifter holds a fresh word
  logic                 sclk_q;    // Master clock level
  logic                 sin_q;     // Slave clock of last cycle
  logic                 din_q;     // Data input of last cycle
  logic                 edge_q;    // Slave edge in last cycle
  logic                 done_q;    // Last bit sampled last cycle

  // ========================================================================
  // Decoded controls
  logic       en;         // Port enabled
  logic       is_master;  // Master role
  logic       cpol;       // Idle clock level
  logic       cpha;       // Clock phase
  logic       rx_keep;    // Received words are stored
  logic       drive;      // Transmit line is driven
  logic [3:0] nbits;      // Bits per word
  logic [3:0] last;       // Index of the final edge
  logic       din;        // Selected data input

  assign en        = ctrl[ssu_pkg::CTRL_EN];
  assign is_master = ctrl[ssu_pkg::CTRL_MASTER];
  assign cpol      = ctrl[ssu_pkg::CTRL_CPOL];
  assign cpha      = ctrl[ssu_pkg::CTRL_CPHA];
  // A zero width field would be one bit, so it is read as two
  assign nbits = (ctrl[ssu_pkg::CTRL_WID_LO +: 3] == 3'h0) ? 4'h2
               : {1'b0, ctrl[ssu_pkg::CTRL_WID_LO +: 3]} + 4'h1;
  assign last  = 4'((nbits << 1) - 4'h1);
  // Half duplex: either store what comes in, or drive what goes out
  assign rx_keep = !ctrl[ssu_pkg::CTRL_HALF] || !ctrl[ssu_pkg::CTRL_TXDIR];
  assign drive   = !ctrl[ssu_pkg::CTRL_HALF] || ctrl[ssu_pkg::CTRL_TXDIR];
  // Receive line depends on role
  assign din = is_master ? master_in_slave_out_pin_i : master_out_slave_in_pin_i;

  // ========================================================================
  // Sub blocks
  ssu_core_if cif ();

  ssu_baud u_baud (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.baud)
  );

  ssu_shift u_shift (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.shifter)
  );

  // ========================================================================
  // Edge detection
  logic s_lead;    // Slave leading edge
  logic s_trail;   // Slave trailing edge
  logic act;       // An edge is processed this cycle
  logic lead;      // Processed edge is leading
  logic trail;     // Processed edge is trailing
  logic start_m;   // Master begins a word
  logic start_s;   // Slave preloads a word
  logic do_load;   // Holding buffer moves to shifter
  logic wb_hit;    // Bus access completes this cycle
  logic rd_rx;     // Receive buffer is read
  logic wr_tx;     // Transmit buffer is written

  // Slave edges are leaving or returning to the idle level
  assign s_lead  = en && !is_master && (sclk_i != cpol) && (sin_q == cpol);
  assign s_trail = en && !is_master && (sclk_i == cpol) && (sin_q != cpol);

  // Master edges come from divider ticks; even index is leading
  always_comb begin
    if (is_master) begin
      act   = en && state == ssu_pkg::SSU_RUN && cif.tick;
      lead  = act && !h[0];
      trail = act && h[0];
    end else begin
      // A slave word begins on its first leading edge
      act   = (state == ssu_pkg::SSU_RUN) ? (s_lead || s_trail) : s_lead;
      lead  = act && s_lead;
      trail = act && s_trail;
    end
  end

  // Word start conditions
  assign start_m = en && is_master && state == ssu_pkg::SSU_IDLE && tx_full;
  assign start_s = en && !is_master && state == ssu_pkg::SSU_IDLE && tx_full && !loaded
                   && !s_lead;
  assign do_load = start_m || start_s;

  // ========================================================================
  // Shifter control
  assign cif.reload    = baud_rl;
  assign cif.run       = en && is_master && state == ssu_pkg::SSU_RUN;
  assign cif.load      = do_load;
  assign cif.load_data = tx_buf;
  assign cif.in_bit    = din;
  assign cif.lsb_first = ctrl[ssu_pkg::CTRL_LSB];
  assign cif.nbits     = nbits;
  // Phase 0 samples on leading and shifts on trailing; phase 1 the reverse
  assign cif.sample    = cpha ? trail : lead;
  assign cif.shift     = cpha ? (lead && h != 4'h0) : (trail && h != last);

  // ========================================================================
  // Word engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= ssu_pkg::SSU_IDLE;
      h      <= 4'h0;
      loaded <= 1'b0;
    end else if (!en) begin
      // Disabling abandons any word in flight
      state  <= ssu_pkg::SSU_IDLE;
      h      <= 4'h0;
      loaded <= 1'b0;
    end else if (act && h == last) begin
      // Final edge ends the word
      state  <= ssu_pkg::SSU_IDLE;
      h      <= 4'h0;
      loaded <= 1'b0;
    end else if (act) begin
      state <= ssu_pkg::SSU_RUN;
      h     <= h + 4'h1;
    end else if (start_m) begin
      state  <= ssu_pkg::SSU_RUN;
      loaded <= 1'b1;
    end else if (start_s) begin
      loaded <= 1'b1;
    end
  end

  // Master clock toggles each tick and rests at the idle level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
    end else if (state == ssu_pkg::SSU_IDLE || !en || !is_master) begin
      sclk_q <= cpol;
    end else if (cif.tick) begin
      sclk_q <= !sclk_q;
    end
  end

  // Slave pin history for edge, phase and rate checks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sin_q  <= 1'b0;
      din_q  <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      sin_q  <= sclk_i;
      din_q  <= din;
      edge_q <= s_lead || s_trail;
    end
  end

  // Final sample flags a word; copy waits a cycle for the shifter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cif.sample && h == (cpha ? last : 4'(last - 4'h1));
    end
  end

  // ========================================================================
  // Error detection
  logic [3:0] err_set; // Errors raised this cycle

  always_comb begin
    err_set         = 4'h0;
    // New word while the previous one was not read
    err_set[ssu_pkg::ERR_RE] = done_q && rx_keep && rx_full && !rd_rx;
    // Slave data moved exactly at its sampling edge
    err_set[ssu_pkg::ERR_PE] = !is_master && cif.sample && din != din_q;
    // Slave clock edges in back to back cycles are too fast to follow
    err_set[ssu_pkg::ERR_BE] = !is_master && act && edge_q;
    // Slave word begins with nothing loaded; old shifter contents go out
    err_set[ssu_pkg::ERR_TE] = !is_master && act && state == ssu_pkg::SSU_IDLE && !loaded
                               && drive;
  end

  // ========================================================================
  // Bus slave
  // Writes and read side effects act at the edge that samples ack
  assign wb_hit = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign rd_rx  = wb_hit && !wb_we_i && {wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_RXDATA;
  assign wr_tx  = wb_hit && wb_we_i && wb_sel_i[0]
                  && {wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_TXDATA;

  // One wait state, then ack for a single cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data registered before ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      if ({wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_CTRL) begin
        wb_dat_o <= {21'h000000, ctrl};
      end else if ({wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_BAUD) begin
        wb_dat_o <= {16'h0000, baud_rl};
      end else if ({wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_RXDATA) begin
        wb_dat_o <= {24'h000000, rx_buf};
      end else if ({wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_STATUS) begin
        wb_dat_o <= {25'h0000000, err, state == ssu_pkg::SSU_RUN, rx_full, !tx_full};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Control register, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= ssu_pkg::CTRL_RST;
    end else if (wb_hit && wb_we_i && {wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[10:8] <= wb_dat_i[10:8];
      end
    end
  end

  // Baud reload; a change takes hold at the next reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_rl <= ssu_pkg::BAUD_RST;
    end else if (wb_hit && wb_we_i && {wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_BAUD) begin
      if (wb_sel_i[0]) begin
        baud_rl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        baud_rl[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ========================================================================
  // Transmit buffer
  // A write in the same cycle as a load refills it; writing a full
  // buffer replaces the waiting word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf  <= 8'h00;
      tx_full <= 1'b0;
    end else if (wr_tx) begin
      tx_buf  <= wb_dat_i[7:0];
      tx_full <= 1'b1;
    end else if (do_load) begin
      tx_full <= 1'b0;
    end
  end

  // ========================================================================
  // Receive buffer
  // New word wins over a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf  <= 8'h00;
      rx_full <= 1'b0;
    end else if (done_q && rx_keep) begin
      rx_buf  <= cif.rx_word;
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  // Sticky errors, write one to clear, a new error wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err <= 4'h0;
    end else if (wb_hit && wb_we_i && wb_sel_i[0]
                 && {wb_adr_i[7:2], 2'b00} == ssu_pkg::OFF_STATUS) begin
      err <= (err & ~wb_dat_i[ssu_pkg::ST_ERR +: 4]) | err_set;
    end else begin
      err <= err | err_set;
    end
  end

  // ========================================================================
  // Service requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_req_o <= 1'b0;
      rx_full_req_o  <= 1'b0;
      err_req_o      <= 1'b0;
    end else begin
      tx_empty_req_o <= do_load;
      rx_full_req_o  <= done_q && rx_keep;
      err_req_o      <= |err_set;
    end
  end

  // ========================================================================
  // Pins
  // Clock pin driven only by an enabled master
  assign master_shift_clock_out_o = sclk_q;
  assign sclk_oe_o                = en && is_master;
  // Transmit line is the role's output pin; the other stays released
  assign master_out_slave_in_pin_o    = cif.out_bit;
  assign master_out_slave_in_pin_oe_o = en && is_master && drive;
  assign master_in_slave_out_pin_o    = cif.out_bit;
  assign master_in_slave_out_pin_oe_o = en && !is_master && drive;

endmodule // ssu_top
`default_nettype wire

/* File: verif/ssu_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ======
// Port checks of the serial unit
module ssu_top_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins and requests
  input wire logic        master_shift_clock_out_o,
  input wire logic        sclk_oe_o,
  input wire logic        master_out_slave_in_pin_oe_o,
  input wire logic        master_in_slave_out_pin_oe_o,
  input wire logic        tx_empty_req_o,
  input wire logic        rx_full_req_o
);
  logic rd_req; // Read seen, not yet answered
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ======
  // Bus handshake
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack_resp; s_req |=> s_ack_once; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack not one cycle");
  // Read data only moves on a read
  property p_dat_hold; $changed(wb_dat_o) |-> $past(rd_req); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  // Reset must quiet ack, the clock enable and the clock level, so it is never disabled
  property p_rst_quiet;
    disable iff (1'b0) rst_i |=> !wb_ack_o && !sclk_oe_o && !master_shift_clock_out_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
  // ======
  // Pin roles
  property p_pins_excl; !(master_out_slave_in_pin_oe_o && master_in_slave_out_pin_oe_o);
  endproperty
  a_pins_excl: assert property (p_pins_excl) else $error("both data pins driven");
  property p_clk_owner; sclk_oe_o |-> !master_in_slave_out_pin_oe_o; endproperty
  a_clk_owner: assert property (p_clk_owner) else $error("master drives slave pin");
  // A clock edge without the clock driven would be a slave making a clock;
  // only a control write two cycles back may move the resting level
  property p_clk_quiet;
    $changed(master_shift_clock_out_o) && !sclk_oe_o |-> $past(wb_ack_o && wb_we_i, 2);
  endproperty
  a_clk_quiet: assert property (p_clk_quiet) else $error("clock moved undriven");
  // ======
  // Requests are single pulses
  property p_txe_pulse; tx_empty_req_o |=> !tx_empty_req_o; endproperty
  a_txe_pulse: assert property (p_txe_pulse) else $error("tx request too long");
  property p_rxf_pulse; rx_full_req_o |=> !rx_full_req_o; endproperty
  a_rxf_pulse: assert property (p_rxf_pulse) else $error("rx request too long");
endmodule // ssu_top_asserts
bind ssu_top ssu_top_asserts chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .master_shift_clock_out_o, .sclk_oe_o,
  .master_out_slave_in_pin_oe_o, .master_in_slave_out_pin_oe_o, .tx_empty_req_o,
  .rx_full_req_o);
`default_nettype wire

/* File: verif/ssu_spi_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ======
// Far slave: phase zero samples on leading edge, phase one on trailing
module ssu_spi_slave_model (
  // Link pins
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // Set-up from the bench
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       ld_i,
  input  wire logic [7:0] word_i,
  output logic      [7:0] rx_o
);
  logic [7:0] tx;    // Outgoing word, top bit on the line
  logic       fresh; // No shifting edge since the word was loaded
  // Works on the pin itself, as a real slave has no core clock
  always @(sclk_i or posedge ld_i) begin
    if (ld_i) begin
      tx = word_i;
      fresh = 1'b1;
    end else if ((sclk_i != cpol_i) != cpha_i) begin // Sampling edge
      rx_o = {rx_o[6:0], mosi_i};
    end else begin // Shifting edge; phase one keeps the first bit; refill toggles
      if (!(cpha_i && fresh)) tx = {tx[6:0], ~tx[7]};
      fresh = 1'b0;
    end
  end
  assign miso_o = tx[7];
endmodule // ssu_spi_slave_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ======
// Serial unit bench, master role against the slave model
module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, ld, cpol, cpha;
  logic [7:0]  adr, mword, mrx;
  logic [31:0] dat, rdat, dat_o;
  logic        ack, clk_out, clk_oe, mosi, mosi_oe, miso_o, miso_oe, miso, txe, rxf, err;
  int          fails, num_checks, ntxe, nrxf, nerr, tick, n;
  wire sclk_w = clk_oe ? clk_out : cpol; // Idle pin rests at polarity
  wire mosi_w = mosi_oe ? mosi : ~mosi;  // Undriven line shows no old bit
  // Rows: control, baud, tx word, model word, expected rx, expected far rx
  // Row 4 is half duplex receive, so the far end sees the released line
  logic [10:0] rc [6] = '{11'h703, 11'h70F, 11'h103, 11'h40F, 11'h723, 11'h513};
  logic [15:0] rb [6] = '{16'h0000, 16'h0002, 16'h0001, 16'h0000, 16'h0000, 16'h0001};
  logic [7:0]  rt [6] = '{8'hA5, 8'h1E, 8'hFE, 8'h0B, 8'h0F, 8'h2D};
  logic [7:0]  rm [6] = '{8'h3C, 8'hC4, 8'h40, 8'hD0, 8'h81, 8'h9C};
  logic [7:0]  rd [6] = '{8'h3C, 8'h23, 8'h01, 8'h0B, 8'h81, 8'h27};
  logic [7:0]  rs [6] = '{8'hA5, 8'h78, 8'h02, 8'h1A, 8'hF0, 8'h2D};
  ssu_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sclk_i(sclk_w), .master_shift_clock_out_o(clk_out),
    .sclk_oe_o(clk_oe), .master_out_slave_in_pin_i(mosi_w),
    .master_out_slave_in_pin_o(mosi), .master_out_slave_in_pin_oe_o(mosi_oe),
    .master_in_slave_out_pin_i(miso), .master_in_slave_out_pin_o(miso_o),
    .master_in_slave_out_pin_oe_o(miso_oe), .tx_empty_req_o(txe),
    .rx_full_req_o(rxf), .err_req_o(err));
  ssu_spi_slave_model part_u (.sclk_i(sclk_w), .mosi_i(mosi_w), .miso_o(miso),
    .cpol_i(cpol), .cpha_i(cpha), .ld_i(ld), .word_i(mword), .rx_o(mrx));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Count request pulses; cut a hang short
  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (txe === 1'b1) ntxe <= ntxe + 1;
    if (rxf === 1'b1) nrxf <= nrxf + 1;
    if (err === 1'b1) nerr <= nerr + 1;
    if (tick == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++k < 50);
    if (ack !== 1'b1) fails++;
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_rx(input int c);
    int k;
    k = 0;
    while (nrxf < c && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (nrxf < c) fails++;
  endtask
  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {fails, num_checks, ntxe, nrxf, nerr, tick} = '0;
    {rst_i, cyc, stb, we, ld, cpol, cpha, adr, mword, dat} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ssu_pkg::OFF_CTRL, 0);
    chk("ctrl reset", rdat, 32'h700);
    wb(1'b0, ssu_pkg::OFF_BAUD, 0);
    chk("baud reset", rdat, 0);
    wb(1'b0, 8'h14, 0);
    chk("unmapped", rdat, 0);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ssu_pkg::OFF_CTRL, {21'h0, rc[i]});
      cpol <= rc[i][3];
      cpha <= rc[i][4];
      wb(1'b1, ssu_pkg::OFF_BAUD, {16'h0, rb[i]});
      mword <= rm[i];
      ld <= 1'b1;
      @(posedge clk_i);
      ld <= 1'b0;
      wb(1'b1, ssu_pkg::OFF_TXDATA, {24'h0, rt[i]});
      wait_rx(i + 1);
      wb(1'b0, ssu_pkg::OFF_RXDATA, 0);
      chk("rx word", rdat, {24'h0, rd[i]});
      n = rc[i][10:8] + 1;
      chk("far rx", {24'h0, mrx & (8'hFF >> (8 - n))}, {24'h0, rs[i]});
      wb(1'b0, ssu_pkg::OFF_STATUS, 0);
      chk("status", rdat & 32'h3, 32'h1);
    end
    chk("tx pulses", ntxe, 6);
    // Second word written while the first shifts, rx left unread
    wb(1'b1, ssu_pkg::OFF_TXDATA, 32'h55);
    wb(1'b1, ssu_pkg::OFF_TXDATA, 32'h66);
    wait_rx(8);
    chk("rx pulses", nrxf, 8);
    chk("err pulses", nerr, 1);
    wb(1'b0, ssu_pkg::OFF_STATUS, 0);
    chk("overrun", rdat & 32'h8, 32'h8);
    wb(1'b1, ssu_pkg::OFF_STATUS, 32'h78);
    wb(1'b0, ssu_pkg::OFF_STATUS, 0);
    chk("err clear", rdat & 32'h78, 0);
    // Reset in mid-word returns the unit to its idle defaults
    wb(1'b1, ssu_pkg::OFF_TXDATA, 32'h3C);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ssu_pkg::OFF_CTRL, 0);
    chk("ctrl after reset", rdat, 32'h700);
    wb(1'b0, ssu_pkg::OFF_STATUS, 0);
    chk("status after reset", rdat, 32'h1);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
